// ===== verilog/cdp_channel_dynamics.sv
// Purpose: per-channel polarity, high-pass, gate/expander and compressor stage
// Assumes: one sample per in_valid, tagged with its channel id; control logic on mclk
// Notes: gains smoothed per sample in dB; channel ids 44..47 are pass-through paths
`timescale 1ns/1ps
`default_nettype none
module cdp_channel_dynamics (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [5:0] in_ch,
  input wire logic signed [23:0] in_sample,
  output logic out_valid,
  output logic [5:0] out_ch,
  output logic signed [23:0] out_sample,
  output logic out_link_only,
  output logic mon_valid,
  output logic signed [23:0] mon_sample,
  input wire logic [5:0] sel_ch,
  input wire logic sel_solo,
  input wire logic cfg_wr,
  input wire logic cfg_pol,
  input wire logic [9:0] cfg_hpf_hz,
  input wire logic cfg_gate_on,
  input wire logic cfg_gate_exp,
  input wire logic cfg_key_listen,
  input wire logic [9:0] cfg_key_hz,
  input wire logic [5:0] cfg_gate_thr,
  input wire logic [6:0] cfg_gate_range,
  input wire logic [14:0] cfg_gate_att,
  input wire logic [14:0] cfg_gate_rel,
  input wire logic cfg_comp_on,
  input wire logic cfg_comp_soft,
  input wire logic cfg_comp_auto,
  input wire logic [5:0] cfg_comp_thr,
  input wire logic [3:0] cfg_comp_ratio,
  input wire logic [14:0] cfg_comp_att,
  input wire logic [14:0] cfg_comp_rel,
  input wire logic [4:0] cfg_comp_gain,
  output logic led_pol,
  output logic led_hpf,
  output logic led_gate,
  output logic led_comp
);

  typedef struct packed {
    cdp_pkg::cdp_prm_type [cdp_pkg::NCH-1:0] prm;
    logic [cdp_pkg::NCH-1:0][31:0] hp;
    logic [cdp_pkg::NCH-1:0][31:0] kh;
    logic [cdp_pkg::NCH-1:0][31:0] kl;
    logic [cdp_pkg::NCH-1:0][15:0] gst;
    logic [cdp_pkg::NCH-1:0][15:0] cst;
    logic out_valid;
    logic [5:0] out_ch;
    logic [23:0] out_sample;
    logic out_link;
    logic mon_valid;
    logic [23:0] mon_sample;
  } cdp_core_type;

  cdp_core_type s;
  cdp_core_type next_s;

  logic in_ok;
  logic [5:0] ch;
  logic [5:0] sel;
  cdp_pkg::cdp_prm_type p;
  cdp_pkg::cdp_prm_type ps;
  cdp_pkg::cdp_class_type cl;
  cdp_pkg::cdp_class_type cl_sel;
  logic pol_use;
  logic hpf_use;
  logic key_use;
  logic gate_act;
  logic comp_act;
  logic signed [23:0] x_pol;
  logic signed [31:0] hp_new;
  logic signed [23:0] x_hp;
  logic [13:0] k_key;
  logic signed [31:0] kh_new;
  logic signed [23:0] key_hp;
  logic signed [31:0] kl_new;
  logic signed [23:0] key_sig;
  logic signed [9:0] g_lvl;
  logic signed [9:0] c_lvl;
  logic [7:0] gate_db;
  logic [7:0] comp_db;
  logic [15:0] gst_new;
  logic [15:0] cst_new;
  logic [14:0] c_att_t;
  logic [14:0] c_rel_t;
  logic [4:0] mk;
  logic signed [9:0] tot_db;
  logic signed [9:0] gate_neg;
  logic signed [23:0] y;
  logic signed [23:0] gated;

  // ids beyond the map fall back to index 0 but are never processed
  assign in_ok = in_valid && (in_ch < cdp_pkg::NCH_ID);
  assign ch = (in_ch < cdp_pkg::NCH_ID) ? in_ch : 6'h00;
  assign sel = (sel_ch < cdp_pkg::NCH_ID) ? sel_ch : 6'h00;
  assign p = s.prm[ch];
  assign ps = s.prm[sel];
  assign cl = cdp_pkg::cdp_class(in_ch);
  assign cl_sel = cdp_pkg::cdp_class(sel);

  // stage availability by channel class
  // inputs only invert
  assign pol_use = p.pol && (cl == cdp_pkg::CL_IN);
  assign hpf_use = (p.hpf_hz >= cdp_pkg::HPF_MIN_HZ) && (cl inside {cdp_pkg::CL_IN,
                   cdp_pkg::CL_AUX, cdp_pkg::CL_FX, cdp_pkg::CL_RET});
  assign key_use = (p.key_hz != 10'h000);
  assign gate_act = p.gate_on && (cl != cdp_pkg::CL_RAW);
  assign comp_act = p.comp_on && (cl != cdp_pkg::CL_RAW);

  // polarity flip
  // widened before negation so full-scale negative saturates instead of wrapping
  assign x_pol = pol_use ? cdp_pkg::cdp_sat24(-48'(in_sample)) : in_sample;

  // first-order high-pass
  // output is input minus a one-pole low-pass, giving a 6 dB per octave skirt
  assign hp_new = cdp_pkg::cdp_lp(signed'(s.hp[ch]), x_pol, cdp_pkg::cdp_coef(p.hpf_hz));
  assign x_hp = hpf_use ? cdp_pkg::cdp_sat24(48'(x_pol) - 48'(hp_new >>> 8)) : x_pol;

  // key band detector
  // high-pass then low-pass at the key frequency forms a band around it
  assign k_key = cdp_pkg::cdp_coef(p.key_hz);
  assign kh_new = cdp_pkg::cdp_lp(signed'(s.kh[ch]), x_hp, k_key);
  assign key_hp = cdp_pkg::cdp_sat24(48'(x_hp) - 48'(kh_new >>> 8));
  assign kl_new = cdp_pkg::cdp_lp(signed'(s.kl[ch]), key_hp, k_key);
  assign key_sig = key_use ? kl_new[31:8] : x_hp;

  // detector levels; compressor sees the level after the gate's attenuation
  assign g_lvl = cdp_pkg::cdp_level(key_sig);
  assign c_lvl = cdp_pkg::cdp_level(x_hp) - $signed({2'b00, s.gst[ch][15:8]});

  cdp_dyn_law u_law (
    .g_lvl(g_lvl),
    .c_lvl(c_lvl),
    .gate_exp(p.gate_exp),
    .gate_thr(p.gate_thr),
    .gate_range(p.gate_range),
    .comp_thr(p.comp_thr),
    .comp_ratio(p.comp_ratio),
    .comp_soft(p.comp_soft),
    .gate_db(gate_db),
    .comp_db(comp_db)
  );

  // gate ballistics: rising attenuation is closing, so it follows the release time
  // opening time
  assign gst_new = cdp_pkg::cdp_glide(s.gst[ch], gate_act ? {gate_db, 8'h00} : 16'h0000,
                                      cdp_pkg::cdp_tshift(p.gate_rel),
                                      cdp_pkg::cdp_tshift(p.gate_att));

  assign c_att_t = p.comp_auto ? cdp_pkg::AUTO_ATT_T : p.comp_att;
  assign c_rel_t = p.comp_auto ? cdp_pkg::AUTO_REL_T : p.comp_rel;

  assign cst_new = cdp_pkg::cdp_glide(s.cst[ch], comp_act ? {comp_db, 8'h00} : 16'h0000,
                                      cdp_pkg::cdp_tshift(c_att_t),
                                      cdp_pkg::cdp_tshift(c_rel_t));

  assign mk = comp_act ? p.comp_gain : 5'h00;
  assign tot_db = $signed({5'h00, mk}) - $signed({2'b00, gst_new[15:8]})
                  - $signed({2'b00, cst_new[15:8]});

  // stage order
  // one combined gain keeps the chain to a single multiply and a single rounding
  assign y = cdp_pkg::cdp_sat24((48'(x_hp) * $signed({1'b0, cdp_pkg::cdp_db2lin(tot_db)}))
                                >>> 16);

  // removed part
  // the gate alone is re-applied so the monitor hears only what the gate takes out
  assign gate_neg = -$signed({2'b00, gst_new[15:8]});
  assign gated = cdp_pkg::cdp_sat24((48'(x_hp) * $signed({1'b0,
                                    cdp_pkg::cdp_db2lin(gate_neg)})) >>> 16);

  // next state: parameter writes and per-sample update
  always_comb
  begin
    next_s = s;
    next_s.out_valid = 1'b0;
    next_s.mon_valid = 1'b0;
    if (cfg_wr && (sel_ch < cdp_pkg::NCH_ID))
    begin
      next_s.prm[sel_ch].pol = cfg_pol;
      next_s.prm[sel_ch].hpf_hz = (cfg_hpf_hz > cdp_pkg::HPF_MAX_HZ) ?
                                  cdp_pkg::HPF_MAX_HZ : cfg_hpf_hz;
      next_s.prm[sel_ch].gate_on = cfg_gate_on;
      next_s.prm[sel_ch].gate_exp = cfg_gate_exp;
      next_s.prm[sel_ch].key_listen = cfg_key_listen;
      next_s.prm[sel_ch].key_hz = (cfg_key_hz > cdp_pkg::HPF_MAX_HZ) ?
                                  cdp_pkg::HPF_MAX_HZ : cfg_key_hz;
      next_s.prm[sel_ch].gate_thr = (cfg_gate_thr > cdp_pkg::GATE_THR_OFF) ?
                                    cdp_pkg::GATE_THR_OFF : cfg_gate_thr;
      next_s.prm[sel_ch].gate_range = (cfg_gate_range > cdp_pkg::GATE_RANGE_MAX) ?
                                      cdp_pkg::GATE_RANGE_MAX : cfg_gate_range;
      next_s.prm[sel_ch].gate_att = cdp_pkg::cdp_clamp15(cfg_gate_att,
                                    cdp_pkg::GATE_ATT_MIN, cdp_pkg::GATE_ATT_MAX);
      next_s.prm[sel_ch].gate_rel = cdp_pkg::cdp_clamp15(cfg_gate_rel,
                                    cdp_pkg::GATE_REL_MIN, cdp_pkg::GATE_REL_MAX);
      next_s.prm[sel_ch].comp_on = cfg_comp_on;
      next_s.prm[sel_ch].comp_soft = cfg_comp_soft;
      next_s.prm[sel_ch].comp_auto = cfg_comp_auto;
      next_s.prm[sel_ch].comp_thr = (cfg_comp_thr > cdp_pkg::COMP_THR_MAX) ?
                                    cdp_pkg::COMP_THR_MAX : cfg_comp_thr;
      next_s.prm[sel_ch].comp_ratio = (cfg_comp_ratio < cdp_pkg::RATIO_MIN) ?
                                      cdp_pkg::RATIO_MIN : ((cfg_comp_ratio >
                                      cdp_pkg::RATIO_MAX) ? cdp_pkg::RATIO_MAX :
                                      cfg_comp_ratio);
      next_s.prm[sel_ch].comp_att = cdp_pkg::cdp_clamp15(cfg_comp_att,
                                    cdp_pkg::COMP_ATT_MIN, cdp_pkg::COMP_ATT_MAX);
      next_s.prm[sel_ch].comp_rel = cdp_pkg::cdp_clamp15(cfg_comp_rel,
                                    cdp_pkg::COMP_REL_MIN, cdp_pkg::COMP_REL_MAX);
      next_s.prm[sel_ch].comp_gain = (cfg_comp_gain > cdp_pkg::GAIN_MAX_DB) ?
                                     cdp_pkg::GAIN_MAX_DB : cfg_comp_gain;
    end
    if (in_ok)
    begin
      next_s.out_valid = 1'b1;
      next_s.out_ch = in_ch;
      if (cl == cdp_pkg::CL_RAW)
      begin
        next_s.out_sample = in_sample;
        next_s.out_link = 1'b1;
      end
      else
      begin
        next_s.out_sample = y;
        next_s.out_link = 1'b0;
        // filter memories only advance while their stage is in use
        if (hpf_use)
          next_s.hp[ch] = hp_new;
        if (key_use)
        begin
          next_s.kh[ch] = kh_new;
          next_s.kl[ch] = kl_new;
        end
        next_s.gst[ch] = gst_new;
        next_s.cst[ch] = cst_new;
        if (p.key_listen && sel_solo && (in_ch == sel_ch) && gate_act)
        begin
          next_s.mon_valid = 1'b1;
          next_s.mon_sample = cdp_pkg::cdp_sat24(48'(x_hp) - 48'(gated));
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.prm <= {cdp_pkg::NCH{cdp_pkg::PRM_RESET}};
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign out_valid = s.out_valid;
  assign out_ch = s.out_ch;
  assign out_sample = s.out_sample;
  assign out_link_only = s.out_link;
  assign mon_valid = s.mon_valid;
  assign mon_sample = s.mon_sample;

  // indicators for the selected channel
  // polarity lamp
  assign led_pol = ps.pol && (cl_sel == cdp_pkg::CL_IN);
  assign led_hpf = (ps.hpf_hz >= cdp_pkg::HPF_MIN_HZ) && (cl_sel inside {cdp_pkg::CL_IN,
                   cdp_pkg::CL_AUX, cdp_pkg::CL_FX, cdp_pkg::CL_RET});
  assign led_gate = ps.gate_on && (cl_sel != cdp_pkg::CL_RAW);
  assign led_comp = ps.comp_on && (cl_sel != cdp_pkg::CL_RAW);

endmodule // cdp_channel_dynamics
`default_nettype wire

// ===== verilog/cdp_pkg.sv
// Purpose: constants, types and shared arithmetic for the channel dynamics processor
// Assumes: 24-bit signed samples at 48 kHz; levels in whole dB, 0 dB = full scale
// Notes: times are in units of 0.1 ms; gain smoothing runs once per sample
package cdp_pkg;

  // channel id map
  localparam logic [5:0] NCH_ID = 6'h30;
  localparam int NCH = 32'h30;
  localparam logic [5:0] CH_AUX = 6'h18;
  localparam logic [5:0] CH_FX = 6'h22;
  localparam logic [5:0] CH_RET = 6'h24;
  localparam logic [5:0] CH_SUB = 6'h26;
  localparam logic [5:0] CH_MAIN = 6'h2a;
  localparam logic [5:0] CH_RAW = 6'h2c;

  // filter limits and coefficient scale (2*pi*f/fs in q16 = f*549/64)
  localparam logic [9:0] HPF_MIN_HZ = 10'h018;
  localparam logic [9:0] HPF_MAX_HZ = 10'h3e8;
  localparam int HPF_MUL = 32'h225;
  localparam int HPF_SH = 32'h6;

  // gate and compressor limits
  localparam logic [5:0] GATE_THR_MAX = 6'h38;
  localparam logic [5:0] GATE_THR_OFF = 6'h39;
  localparam logic [6:0] GATE_RANGE_MAX = 7'h56;
  localparam logic [14:0] GATE_ATT_MIN = 15'h0002;
  localparam logic [14:0] GATE_ATT_MAX = 15'h05dc;
  localparam logic [14:0] GATE_REL_MIN = 15'h01f4;
  localparam logic [14:0] GATE_REL_MAX = 15'h4e20;
  localparam logic [5:0] COMP_THR_MAX = 6'h38;
  localparam logic [3:0] RATIO_MIN = 4'h1;
  localparam logic [3:0] RATIO_MAX = 4'he;
  localparam logic [14:0] COMP_ATT_MIN = 15'h0002;
  localparam logic [14:0] COMP_ATT_MAX = 15'h05dc;
  localparam logic [14:0] COMP_REL_MIN = 15'h0190;
  localparam logic [14:0] COMP_REL_MAX = 15'h2710;
  localparam logic [4:0] GAIN_MAX_DB = 5'h1c;
  localparam int KNEE_DB = 32'h8;
  localparam int KNEE_SH = 32'h3;

  // automatic compressor timing
  localparam int TIME_UNITS_PER_MS = 32'ha;
  localparam int AUTO_ATT_MS = 32'ha;
  localparam int AUTO_REL_MS = 32'h96;
  localparam logic [14:0] AUTO_ATT_T = 15'(AUTO_ATT_MS * TIME_UNITS_PER_MS);
  localparam logic [14:0] AUTO_REL_T = 15'(AUTO_REL_MS * TIME_UNITS_PER_MS);
  localparam int SAMPLE_RATE_HZ = 32'hbb80;
  localparam int TSTEP_MUL = (SAMPLE_RATE_HZ + 32'h270f) / 32'h2710;

  // level and gain conversion
  localparam int LVL_FS_OFS = 32'h84;
  localparam logic signed [9:0] LVL_FLOOR = -10'sh08c;
  localparam int DB_STEP = 32'h6;
  localparam int LIN_UNITY_Q = 32'h16;
  localparam int LIN_MAX_U = 32'ha0;
  localparam logic [5:0][16:0] DB_FRAC = {17'h1c824, 17'h19660, 17'h16a0a,
                                          17'h1428a, 17'h11f5a, 17'h10000};

  typedef enum logic [2:0]
  {
    CL_IN = 3'b000,
    CL_AUX = 3'b001,
    CL_FX = 3'b010,
    CL_RET = 3'b011,
    CL_SUB = 3'b100,
    CL_MAIN = 3'b101,
    CL_RAW = 3'b110
  } cdp_class_type;

  typedef struct packed {
    logic pol;
    logic [9:0] hpf_hz;
    logic gate_on;
    logic gate_exp;
    logic key_listen;
    logic [9:0] key_hz;
    logic [5:0] gate_thr;
    logic [6:0] gate_range;
    logic [14:0] gate_att;
    logic [14:0] gate_rel;
    logic comp_on;
    logic comp_soft;
    logic comp_auto;
    logic [5:0] comp_thr;
    logic [3:0] comp_ratio;
    logic [14:0] comp_att;
    logic [14:0] comp_rel;
    logic [4:0] comp_gain;
  } cdp_prm_type;

  // reset set: all stages off, expander selected, gate threshold at its off end
  localparam cdp_prm_type PRM_RESET = '{pol: 1'b0, hpf_hz: 10'h000, gate_on: 1'b0,
    gate_exp: 1'b1, key_listen: 1'b0, key_hz: 10'h000, gate_thr: GATE_THR_OFF,
    gate_range: GATE_RANGE_MAX, gate_att: GATE_ATT_MIN, gate_rel: GATE_REL_MIN,
    comp_on: 1'b0, comp_soft: 1'b0, comp_auto: 1'b0, comp_thr: 6'h00,
    comp_ratio: RATIO_MIN, comp_att: COMP_ATT_MIN, comp_rel: COMP_REL_MIN,
    comp_gain: 5'h00};

  function automatic cdp_class_type cdp_class(logic [5:0] ch);
    if (ch < CH_AUX) return CL_IN;
    if (ch < CH_FX) return CL_AUX;
    if (ch < CH_RET) return CL_FX;
    if (ch < CH_SUB) return CL_RET;
    if (ch < CH_MAIN) return CL_SUB;
    if (ch < CH_RAW) return CL_MAIN;
    return CL_RAW;
  endfunction

  function automatic logic [14:0] cdp_clamp15(logic [14:0] v, logic [14:0] lo, logic [14:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [23:0] cdp_sat24(logic signed [47:0] v);
    if (v > 48'sh0000007fffff) return 24'sh7fffff;
    if (v < -48'sh000000800000) return -24'sh800000;
    return v[23:0];
  endfunction

  // one-pole coefficient in q16 for a corner in hz
  function automatic logic [13:0] cdp_coef(logic [9:0] hz);
    return 14'((32'(hz) * HPF_MUL) >> HPF_SH);
  endfunction

  // one-pole low-pass step; state is 24.8 fixed point
  function automatic logic signed [31:0] cdp_lp(logic signed [31:0] st, logic signed [23:0] x,
                                                logic [13:0] k);
    logic signed [32:0] d;
    logic signed [47:0] p;
    d = 33'(signed'({x, 8'h00})) - 33'(st);
    p = 48'(d) * $signed({1'b0, k});
    return st + $signed(p[47:16]);
  endfunction

  // peak level in dB from the leading one, half-octave resolution
  function automatic logic signed [9:0] cdp_level(logic signed [23:0] x);
    logic [23:0] a;
    int p;
    int b;
    a = x[23] ? 24'(-x) : x;
    p = -1;
    b = 0;
    for (int i = 0; i < 24; i++)
      if (a[i]) p = i;
    if (p < 0) return LVL_FLOOR;
    if (p > 0) b = int'(a[p-1]);
    return 10'(DB_STEP * p + 3 * b - LVL_FS_OFS);
  endfunction

  // dB to linear gain in q16, 6 dB per octave
  function automatic logic [21:0] cdp_db2lin(logic signed [9:0] db);
    int u;
    int q;
    int r;
    logic [16:0] base;
    u = int'(db) + LVL_FS_OFS;
    if (u < 0) u = 0;
    if (u > LIN_MAX_U) u = LIN_MAX_U;
    q = u / DB_STEP;
    r = u - DB_STEP * q;
    base = DB_FRAC[r];
    if (q >= LIN_UNITY_Q) return 22'({5'h00, base} << (q - LIN_UNITY_Q));
    return 22'(base >> (LIN_UNITY_Q - q));
  endfunction

  // smoothing shift: log2 of the time in samples
  function automatic logic [4:0] cdp_tshift(logic [14:0] t);
    logic [17:0] s;
    logic [4:0] m;
    s = 18'(32'(t) * TSTEP_MUL);
    m = 5'h00;
    for (int i = 0; i < 18; i++)
      if (s[i]) m = 5'(i);
    return m;
  endfunction

  // move a dB*256 state toward its target, at least one step per sample
  function automatic logic [15:0] cdp_glide(logic [15:0] st, logic [15:0] tgt,
                                            logic [4:0] sh_up, logic [4:0] sh_dn);
    logic [15:0] stp;
    stp = 16'h0000;
    if (tgt > st)
    begin
      stp = (tgt - st) >> sh_up;
      return st + ((stp == 16'h0000) ? 16'h0001 : stp);
    end
    if (tgt < st)
    begin
      stp = (st - tgt) >> sh_dn;
      return st - ((stp == 16'h0000) ? 16'h0001 : stp);
    end
    return st;
  endfunction

endpackage

// ===== verilog/cdp_dyn_law.sv
// Purpose: static gain laws of the gate/expander and the compressor
// Assumes: levels in whole dB relative to full scale
// Notes: purely combinational; smoothing lives in the caller
`timescale 1ns/1ps
`default_nettype none
module cdp_dyn_law (
  input wire logic signed [9:0] g_lvl,
  input wire logic signed [9:0] c_lvl,
  input wire logic gate_exp,
  input wire logic [5:0] gate_thr,
  input wire logic [6:0] gate_range,
  input wire logic [5:0] comp_thr,
  input wire logic [3:0] comp_ratio,
  input wire logic comp_soft,
  output logic [7:0] gate_db,
  output logic [7:0] comp_db
);

  logic signed [10:0] below;
  logic signed [10:0] excess;
  logic [15:0] red;

  // gate: attenuation applied below the threshold
  always_comb
  begin
    below = -11'(signed'({5'h00, gate_thr})) - 11'(g_lvl);
    gate_db = 8'h00;
    if (gate_thr > cdp_pkg::GATE_THR_MAX) gate_db = 8'h00;
    else if (below <= 11'sh000) gate_db = 8'h00;
    else if (gate_exp)
      gate_db = (below > 11'(cdp_pkg::GATE_RANGE_MAX)) ? 8'(cdp_pkg::GATE_RANGE_MAX) : 8'(below);
    else
      gate_db = {1'b0, gate_range};
  end

  // compressor: reduction on the excess over threshold
  always_comb
  begin
    excess = 11'(c_lvl) + 11'(signed'({5'h00, comp_thr}));
    red = 16'h0000;
    comp_db = 8'h00;
    if (excess > 11'sh000)
    begin
      red = 16'((32'(excess) * 32'(comp_ratio - 4'h1)) / 32'(comp_ratio));
      if (comp_soft && (32'(excess) < cdp_pkg::KNEE_DB))
        red = 16'((32'(red) * 32'(excess)) >> cdp_pkg::KNEE_SH);
      comp_db = (red > 16'h007f) ? 8'h7f : red[7:0];
    end
  end

endmodule // cdp_dyn_law
`default_nettype wire

// ===== testbench/cdp_dyn_checker.sv
// Purpose: port-level checks for the channel dynamics stage
// Assumes: channel id map of cdp_pkg
// Notes: ballistics are not timed here, only framing, raw pass-through data and the invert light
`timescale 1ns/1ps
`default_nettype none
module cdp_dyn_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [5:0] in_ch,
  input wire logic signed [23:0] in_sample,
  input wire logic out_valid,
  input wire logic [5:0] out_ch,
  input wire logic signed [23:0] out_sample,
  input wire logic out_link_only,
  input wire logic mon_valid,
  input wire logic [5:0] sel_ch,
  input wire logic cfg_wr,
  input wire logic cfg_pol,
  input wire logic led_pol
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_take; in_valid && in_ch < 6'h30 |=> out_valid && out_ch == $past(in_ch); endproperty
  a_take: assert property (p_take) else $error("sample not answered");
  property p_idle; !(in_valid && in_ch < 6'h30) |=> !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("output without sample");
  property p_raw; in_valid && in_ch >= 6'h2c && in_ch < 6'h30 |=> out_link_only
    && out_sample == $past(in_sample); endproperty
  a_raw: assert property (p_raw) else $error("raw path altered");
  property p_cooked; in_valid && in_ch < 6'h2c |=> !out_link_only; endproperty
  a_cooked: assert property (p_cooked) else $error("link flag on processed path");
  property p_ledw; cfg_wr && sel_ch < 6'h18 ##1 $stable(sel_ch) |-> led_pol == $past(cfg_pol);
  endproperty
  a_ledw: assert property (p_ledw) else $error("invert light wrong");
  property p_nopol; sel_ch >= 6'h18 && sel_ch < 6'h30 |-> !led_pol; endproperty
  a_nopol: assert property (p_nopol) else $error("invert light on a bus");
  property p_mon; mon_valid |-> out_valid && out_ch == $past(sel_ch); endproperty
  a_mon: assert property (p_mon) else $error("monitor from other channel");
  property p_hold; !out_valid |-> $stable(out_ch); endproperty
  a_hold: assert property (p_hold) else $error("channel tag moved");
  c_raw: cover property (in_valid && in_ch >= 6'h2c && in_ch < 6'h30);
  c_pol: cover property (cfg_wr && cfg_pol);
  c_mon: cover property (mon_valid);
endmodule // cdp_dyn_checker
bind cdp_channel_dynamics cdp_dyn_checker u_chk (.mclk(mclk), .rst_n(rst_n),
  .in_valid(in_valid), .in_ch(in_ch), .in_sample(in_sample), .out_valid(out_valid),
  .out_ch(out_ch), .out_sample(out_sample), .out_link_only(out_link_only),
  .mon_valid(mon_valid), .sel_ch(sel_ch), .cfg_wr(cfg_wr), .cfg_pol(cfg_pol), .led_pol(led_pol));
`default_nettype wire

// ===== testbench/cdp_mixer_model.sv
// Purpose: routing-side sample source
// Assumes: one request gives one strobe
// Notes: idle lines flip so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module cdp_mixer_model (
  input wire logic mclk,
  input wire logic req,
  input wire logic [5:0] req_ch,
  input wire logic [23:0] req_smp,
  output logic in_valid,
  output logic [5:0] in_ch,
  output logic signed [23:0] in_sample
);
  // launch on the edge after a request, then scramble the idle lines
  always_ff @(posedge mclk)
  begin
    in_valid <= req;
    in_ch <= req ? req_ch : ~in_ch;
    in_sample <= req ? req_smp : ~in_sample;
  end
endmodule // cdp_mixer_model
`default_nettype wire

// ===== testbench/cdp_channel_dynamics_bench.sv
// Purpose: self-checking bench for the channel dynamics stage
// Assumes: all stages off after reset
// Notes: exact values where stages are bypassed, for the makeup gain, and for output plus monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module cdp_channel_dynamics_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic cfg_wr = 1'b0;
  logic sel_solo = 1'b0;
  logic [5:0] rch = 6'h00;
  logic [5:0] sel_ch = 6'h00;
  logic [23:0] rsmp = 24'h000000;
  cdp_pkg::cdp_prm_type p = cdp_pkg::PRM_RESET;
  logic in_valid, out_valid, out_link_only, mon_valid, led_pol, led_hpf, led_gate, led_comp;
  logic [5:0] in_ch, out_ch;
  logic signed [23:0] in_sample, out_sample, mon_sample;
  int errors = 0;
  int total_checks = 0;
  initial forever #12.5 mclk = ~mclk;
  cdp_mixer_model u_mix (.mclk(mclk), .req(req), .req_ch(rch), .req_smp(rsmp),
    .in_valid(in_valid), .in_ch(in_ch), .in_sample(in_sample));
  cdp_channel_dynamics u_dut (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid), .in_ch(in_ch),
    .in_sample(in_sample), .out_valid(out_valid), .out_ch(out_ch), .out_sample(out_sample),
    .out_link_only(out_link_only), .mon_valid(mon_valid), .mon_sample(mon_sample),
    .sel_ch(sel_ch), .sel_solo(sel_solo), .cfg_wr(cfg_wr), .cfg_pol(p.pol),
    .cfg_hpf_hz(p.hpf_hz), .cfg_gate_on(p.gate_on), .cfg_gate_exp(p.gate_exp),
    .cfg_key_listen(p.key_listen), .cfg_key_hz(p.key_hz), .cfg_gate_thr(p.gate_thr),
    .cfg_gate_range(p.gate_range), .cfg_gate_att(p.gate_att), .cfg_gate_rel(p.gate_rel),
    .cfg_comp_on(p.comp_on), .cfg_comp_soft(p.comp_soft), .cfg_comp_auto(p.comp_auto),
    .cfg_comp_thr(p.comp_thr), .cfg_comp_ratio(p.comp_ratio), .cfg_comp_att(p.comp_att),
    .cfg_comp_rel(p.comp_rel), .cfg_comp_gain(p.comp_gain), .led_pol(led_pol),
    .led_hpf(led_hpf), .led_gate(led_gate), .led_comp(led_comp));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // whole parameter set into one channel; lights settle before return
  task automatic cfg(input logic [5:0] c, input cdp_pkg::cdp_prm_type v);
    @(posedge mclk);
    sel_ch <= c;
    p <= v;
    cfg_wr <= 1'b1;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1;
  endtask
  // one sample through the source; bounded wait for the answer
  task automatic send(input logic [5:0] c, input logic [23:0] s, input logic want);
    logic got;
    got = 1'b0;
    @(posedge mclk);
    req <= 1'b1;
    rch <= c;
    rsmp <= s;
    @(posedge mclk);
    req <= 1'b0;
    repeat (4)
    begin
      @(posedge mclk);
      #1;
      got = got | (out_valid === 1'b1);
    end
    `CHK(got, want)
    if (want && !got)
      tally_and_finish();
  endtask
  task automatic t_pol;
    cdp_pkg::cdp_prm_type v;
    v = cdp_pkg::PRM_RESET;
    send(6'h03, 24'h123456, 1'b1);
    `CHK(out_sample, 24'sh123456)
    v.pol = 1'b1;
    cfg(6'h05, v);
    `CHK(led_pol, 1'b1)
    send(6'h05, 24'h001000, 1'b1);
    `CHK(out_sample, 24'shfff000)
    cfg(6'h1e, v);
    `CHK(led_pol, 1'b0)
    send(6'h1e, 24'h001000, 1'b1);
    `CHK(out_sample, 24'sh001000)
    v.comp_on = 1'b1;
    v.hpf_hz = 10'h3e8;
    cfg(6'h2d, v);
    send(6'h2d, 24'h7abcde, 1'b1);
    `CHK(out_sample, 24'sh7abcde)
    `CHK(out_link_only, 1'b1)
    send(6'h32, 24'h000001, 1'b0);
    $display("polarity and raw paths done");
  endtask
  task automatic t_gate;
    cdp_pkg::cdp_prm_type v;
    v = cdp_pkg::PRM_RESET;
    v.gate_on = 1'b1;
    v.comp_on = 1'b1;
    v.hpf_hz = 10'h3e8;
    cfg(6'h1a, v);
    `CHK(({led_hpf, led_gate, led_comp}), 3'b111)
    cfg(6'h28, v);
    `CHK(led_hpf, 1'b0)
    v = cdp_pkg::PRM_RESET;
    v.gate_on = 1'b1;
    v.gate_exp = 1'b0;
    v.key_listen = 1'b1;
    cfg(6'h07, v);
    `CHK(({led_gate, led_comp}), 2'b10)
    send(6'h07, 24'h000100, 1'b1);
    `CHK(out_sample, 24'sh000100)
    $display("gate and lights done");
  endtask
  // high-pass on a negative step, makeup gain, and a closing hard gate with its monitor
  task automatic t_dyn;
    cdp_pkg::cdp_prm_type v;
    v = cdp_pkg::PRM_RESET;
    v.hpf_hz = 10'h3e8;
    cfg(6'h0b, v);
    send(6'h0b, 24'hfff000, 1'b1);
    `CHK((out_sample < 24'sh000000 && out_sample > 24'shfff000), 1'b1)
    v = cdp_pkg::PRM_RESET;
    v.comp_on = 1'b1;
    v.comp_gain = 5'h06;
    cfg(6'h09, v);
    send(6'h09, 24'h000100, 1'b1);
    `CHK(out_sample, 24'sh000200)
    v = cdp_pkg::PRM_RESET;
    v.gate_on = 1'b1;
    v.gate_exp = 1'b0;
    v.key_listen = 1'b1;
    v.gate_thr = 6'h00;
    cfg(6'h0c, v);
    // enough samples for the closing glide to reach a whole dB of depth
    repeat (40) send(6'h0c, 24'h001000, 1'b1);
    `CHK((out_sample < 24'sh001000), 1'b1)
    `CHK(out_sample + mon_sample, 24'sh001000)
    $display("filter, makeup and gate done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    sel_solo <= 1'b1;
    t_pol();
    t_gate();
    t_dyn();
    tally_and_finish();
  end
endmodule // cdp_channel_dynamics_bench
`default_nettype wire
